// file: verilog/rcc_pkg.sv
`default_nettype none
package rcc_pkg;
   localparam int NUM_CH = 2;
   localparam int BIT_SLEEP = 7;
   localparam int BIT_BUF_OFF = 6;
   localparam int GAIN_HI = 5;
   localparam int GAIN_LO = 4;
   localparam int SHIFT_SIGN = 3;
   localparam int SHIFT_MAG_HI = 2;
   localparam int TRIM_HI = 7;
   localparam int TRIM_LO = 4;
   localparam int SWING_HI = 3;
   localparam int SWING_MAG_HI = 2;
   // channel 1 swing register lives elsewhere; seen only as broadcast source
   localparam logic [7:0] ADDR_CH1_SWING_BW = 8'h01;
   localparam logic [7:0] ADDR_CH1_TH_GAIN = 8'h02;
   localparam logic [7:0] ADDR_RSVD_A = 8'h03;
   localparam logic [7:0] ADDR_RSVD_B = 8'h04;
   localparam logic [7:0] ADDR_RSVD_C = 8'h05;
   localparam logic [7:0] ADDR_RSVD_D = 8'h06;
   localparam logic [7:0] ADDR_CH2_SWING_BW = 8'h07;
   localparam logic [7:0] ADDR_CH2_TH_GAIN = 8'h08;
   localparam logic [7:0] ADDR_RSVD_E = 8'h09;
   localparam logic [7:0] ADDR_RSVD_F = 8'h0A;
   localparam logic [7:0] ADDR_TH_GAIN [NUM_CH] = '{8'h02, 8'h08};
   localparam logic [7:0] RST_TH_GAIN = 8'h00;
   localparam logic [7:0] RST_SWING_BW = 8'h00;
   localparam logic [1:0] GAIN_DEFAULT = 2'h0;
   localparam logic [1:0] GAIN_UNDEFINED = 2'h1;
   localparam logic [1:0] GAIN_MEDIUM = 2'h2;
   localparam logic [1:0] GAIN_MINIMUM = 2'h3;
   localparam int SWING_STEP_MV = 50;
   localparam int SWING_UPPER_MV = 250;
   localparam logic [3:0] SWING_UPPER_BASE = 4'(SWING_UPPER_MV / SWING_STEP_MV);
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // arbitrary neutral value
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
   localparam logic PIN_IDLE = 1'b1;
endpackage : rcc_pkg
`default_nettype wire

// file: verilog/rcc_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rcc_pin_if;
   logic sclRise;
   logic sclFall;
   logic sdaLevel;
   logic startSeen;
   logic stopSeen;
   modport sync (output sclRise, sclFall, sdaLevel, startSeen, stopSeen);
   modport ctrl (input sclRise, sclFall, sdaLevel, startSeen, stopSeen);
endinterface : rcc_pin_if
`default_nettype wire

// file: verilog/rcc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   rcc_pin_if.sync pins
);
   logic [1:0] raw;
   logic [1:0] meta_reg;
   logic [1:0] meta_next;
   logic [1:0] sync_reg;
   logic [1:0] sync_next;
   logic [1:0] prev_reg;
   logic [1:0] prev_next;

   assign raw = {sdaIn, sclIn};

   // bit 0 is the clock pin, bit 1 the data pin
   for (genvar i = 0; i < 2; i++) begin : g_pin
      always_comb begin
         meta_next[i] = raw[i];
         sync_next[i] = meta_reg[i];
         prev_next[i] = sync_reg[i];
      end
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_reg[i] <= rcc_pkg::PIN_IDLE;
            sync_reg[i] <= rcc_pkg::PIN_IDLE;
            prev_reg[i] <= rcc_pkg::PIN_IDLE;
         end else begin
            meta_reg[i] <= meta_next[i];
            sync_reg[i] <= sync_next[i];
            prev_reg[i] <= prev_next[i];
         end
      end
   end

   assign pins.sclRise = sync_reg[0] & ~prev_reg[0];
   assign pins.sclFall = ~sync_reg[0] & prev_reg[0];
   assign pins.sdaLevel = sync_reg[1];
   // data moving while the clock stays high marks frame edges
   assign pins.startSeen = sync_reg[0] & prev_reg[0] & prev_reg[1]
      & ~sync_reg[1];
   assign pins.stopSeen = sync_reg[0] & prev_reg[0] & ~prev_reg[1]
      & sync_reg[1];
endmodule : rcc_pin_sync
`default_nettype wire

// file: verilog/rcc_chan_decode.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_chan_decode (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] ctrlByte,
   output logic channelSleep,
   output logic outputBufferOff,
   output logic [1:0] attenuationStep,
   output logic [3:0] decisionShift
);
   logic sleep_next;
   logic bufOff_next;
   logic [1:0] step_next;
   logic [3:0] shift_next;
   logic [3:0] mag;

   always_comb begin
      mag = {1'b0, ctrlByte[rcc_pkg::SHIFT_MAG_HI:0]};
      sleep_next = ctrlByte[rcc_pkg::BIT_SLEEP];
      bufOff_next = ctrlByte[rcc_pkg::BIT_BUF_OFF];
      step_next = ctrlByte[rcc_pkg::GAIN_HI:rcc_pkg::GAIN_LO];
      if (step_next == rcc_pkg::GAIN_UNDEFINED) begin
         step_next = rcc_pkg::GAIN_DEFAULT;
      end
      // sign-magnitude to two's complement, both zeros map to 0
      if (ctrlByte[rcc_pkg::SHIFT_SIGN]) begin
         shift_next = 4'h0 - mag;
      end else begin
         shift_next = mag;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         channelSleep <= 1'b0;
         outputBufferOff <= 1'b0;
         attenuationStep <= rcc_pkg::GAIN_DEFAULT;
         decisionShift <= 4'h0;
      end else begin
         channelSleep <= sleep_next;
         outputBufferOff <= bufOff_next;
         attenuationStep <= step_next;
         decisionShift <= shift_next;
      end
   end
endmodule : rcc_chan_decode
`default_nettype wire

// file: verilog/rcc_ctrl_regs.sv
// Contract
// - control bit 7 puts channel to sleep
// - control bit 6 turns output buffer off
// - bits 5:4 pick gain attenuation step
// - bits 3:0 sign-magnitude decision threshold shift
// - swing register upper nibble trims bandwidth
// - lower nibble sets output swing steps
// - channel 1 control byte at 0x02
// - channel 2 trim and swing at 0x07
// - channel 2 control byte at 0x08
// - channel 2 registers reset to zero
// - 0x03 to 0x06 hold nothing
// - 0x09 and 0x0A hold nothing
// - broadcast mode copies write to all channels
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl_regs #(
   parameter logic [6:0] DEV_ADDR = rcc_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic broadcastWrite,
   output logic [rcc_pkg::NUM_CH-1:0] channelSleep,
   output logic [rcc_pkg::NUM_CH-1:0] outputBufferOff,
   output logic [rcc_pkg::NUM_CH-1:0][1:0] attenuationStep,
   output logic [rcc_pkg::NUM_CH-1:0][3:0] decisionShift,
   output logic [3:0] bandwidthTrim,
   output logic [3:0] outputSwingSteps
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_REG,
      ST_WDATA,
      ST_ACK,
      ST_RDATA,
      ST_RACK
   } rcc_state_t;

   rcc_pin_if pins ();

   rcc_pin_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .pins(pins.sync)
   );

   rcc_state_t state_reg;
   rcc_state_t state_next;
   rcc_state_t ackNext_reg;
   rcc_state_t ackNext_next;
   logic [3:0] bitCnt_reg;
   logic [3:0] bitCnt_next;
   logic [7:0] rxShift_reg;
   logic [7:0] rxShift_next;
   logic [7:0] txShift_reg;
   logic [7:0] txShift_next;
   logic [7:0] ptr_reg;
   logic [7:0] ptr_next;
   logic sdaOe_next;
   logic wrPulse_reg;
   logic wrPulse_next;
   logic [7:0] wrAddr_reg;
   logic [7:0] wrAddr_next;
   logic [7:0] wrData_reg;
   logic [7:0] wrData_next;
   logic [7:0] readByte;
   logic [rcc_pkg::NUM_CH-1:0][7:0] thGain_reg;
   logic [rcc_pkg::NUM_CH-1:0][7:0] thGain_next;
   logic [7:0] swing_reg;
   logic [7:0] swing_next;
   logic [3:0] trim_next;
   logic [3:0] steps_next;

   // register readback; reserved and unmapped bytes read zero
   always_comb begin
      case (ptr_reg)
         rcc_pkg::ADDR_CH1_TH_GAIN: readByte = thGain_reg[0];
         rcc_pkg::ADDR_CH2_SWING_BW: readByte = swing_reg;
         rcc_pkg::ADDR_CH2_TH_GAIN: readByte = thGain_reg[1];
         default: readByte = 8'h00;
      endcase
   end

   // serial slave: bits taken on clock rise, driven after clock fall
   always_comb begin
      state_next = state_reg;
      ackNext_next = ackNext_reg;
      bitCnt_next = bitCnt_reg;
      rxShift_next = rxShift_reg;
      txShift_next = txShift_reg;
      ptr_next = ptr_reg;
      sdaOe_next = sdaOe;
      wrPulse_next = 1'b0;
      wrAddr_next = wrAddr_reg;
      wrData_next = wrData_reg;
      if (pins.stopSeen) begin
         state_next = ST_IDLE;
         sdaOe_next = 1'b0;
      end else if (pins.startSeen) begin
         state_next = ST_ADDR;
         bitCnt_next = 4'h0;
         sdaOe_next = 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (pins.sclRise && bitCnt_reg != rcc_pkg::BYTE_BITS) begin
                  rxShift_next = {rxShift_reg[6:0], pins.sdaLevel};
                  bitCnt_next = bitCnt_reg + 4'h1;
               end else if (pins.sclFall
                  && bitCnt_reg == rcc_pkg::BYTE_BITS) begin
                  bitCnt_next = 4'h0;
                  state_next = ST_ACK;
                  sdaOe_next = 1'b1;
                  case (state_reg)
                     ST_ADDR: begin
                        if (rxShift_reg[7:1] != DEV_ADDR) begin
                           state_next = ST_IDLE;
                           sdaOe_next = 1'b0;
                        end else if (rxShift_reg[0]) begin
                           ackNext_next = ST_RDATA;
                        end else begin
                           ackNext_next = ST_REG;
                        end
                     end
                     ST_REG: begin
                        ptr_next = rxShift_reg;
                        ackNext_next = ST_WDATA;
                     end
                     default: begin
                        wrPulse_next = 1'b1;
                        wrAddr_next = ptr_reg;
                        wrData_next = rxShift_reg;
                        ptr_next = ptr_reg + 8'h01;
                        ackNext_next = ST_WDATA;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (pins.sclFall) begin
                  state_next = ackNext_reg;
                  if (ackNext_reg == ST_RDATA) begin
                     txShift_next = readByte;
                     sdaOe_next = ~readByte[7];
                     bitCnt_next = 4'h1;
                     ptr_next = ptr_reg + 8'h01;
                  end else begin
                     sdaOe_next = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (pins.sclFall) begin
                  if (bitCnt_reg == rcc_pkg::BYTE_BITS) begin
                     sdaOe_next = 1'b0;
                     state_next = ST_RACK;
                  end else begin
                     txShift_next = {txShift_reg[6:0], 1'b0};
                     sdaOe_next = ~txShift_reg[6];
                     bitCnt_next = bitCnt_reg + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (pins.sclRise && pins.sdaLevel) begin
                  state_next = ST_IDLE;
               end else if (pins.sclFall) begin
                  state_next = ST_RDATA;
                  txShift_next = readByte;
                  sdaOe_next = ~readByte[7];
                  bitCnt_next = 4'h1;
                  ptr_next = ptr_reg + 8'h01;
               end
            end
            default: begin
               state_next = state_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         ackNext_reg <= ST_IDLE;
         bitCnt_reg <= 4'h0;
         rxShift_reg <= 8'h00;
         txShift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
         wrPulse_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         wrData_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         ackNext_reg <= ackNext_next;
         bitCnt_reg <= bitCnt_next;
         rxShift_reg <= rxShift_next;
         txShift_reg <= txShift_next;
         ptr_reg <= ptr_next;
         sdaOe <= sdaOe_next;
         sdaOut <= 1'b0;
         wrPulse_reg <= wrPulse_next;
         wrAddr_reg <= wrAddr_next;
         wrData_reg <= wrData_next;
      end
   end

   // register bank; any other address leaves every byte untouched
   always_comb begin
      thGain_next = thGain_reg;
      swing_next = swing_reg;
      if (wrPulse_reg) begin
         for (int c = 0; c < rcc_pkg::NUM_CH; c++) begin
            if (wrAddr_reg == rcc_pkg::ADDR_TH_GAIN[c]) begin
               thGain_next[c] = wrData_reg;
            end
            if (broadcastWrite && (wrAddr_reg == rcc_pkg::ADDR_CH1_TH_GAIN
               || wrAddr_reg == rcc_pkg::ADDR_CH2_TH_GAIN)) begin
               thGain_next[c] = wrData_reg;
            end
         end
         if (wrAddr_reg == rcc_pkg::ADDR_CH2_SWING_BW) begin
            swing_next = wrData_reg;
         end
         if (broadcastWrite
            && wrAddr_reg == rcc_pkg::ADDR_CH1_SWING_BW) begin
            swing_next = wrData_reg;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         thGain_reg <= {rcc_pkg::NUM_CH{rcc_pkg::RST_TH_GAIN}};
         swing_reg <= rcc_pkg::RST_SWING_BW;
      end else begin
         thGain_reg <= thGain_next;
         swing_reg <= swing_next;
      end
   end

   for (genvar c = 0; c < rcc_pkg::NUM_CH; c++) begin : g_ch
      rcc_chan_decode u_dec (
         .clk(clk),
         .rst_n(rst_n),
         .ctrlByte(thGain_reg[c]),
         .channelSleep(channelSleep[c]),
         .outputBufferOff(outputBufferOff[c]),
         .attenuationStep(attenuationStep[c]),
         .decisionShift(decisionShift[c])
      );
   end

   // channel 2 trim and swing, swing counted in 50 mV steps
   always_comb begin
      trim_next = swing_reg[rcc_pkg::TRIM_HI:rcc_pkg::TRIM_LO];
      steps_next = {1'b0, swing_reg[rcc_pkg::SWING_MAG_HI:0]};
      if (swing_reg[rcc_pkg::SWING_HI]) begin
         steps_next = steps_next + rcc_pkg::SWING_UPPER_BASE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bandwidthTrim <= 4'h0;
         outputSwingSteps <= 4'h0;
      end else begin
         bandwidthTrim <= trim_next;
         outputSwingSteps <= steps_next;
      end
   end

   logic wrSleepBit;
   logic wrBufOffBit;
   logic wrToRsvd;
   logic ptrOnRsvd;
   assign wrSleepBit = wrData_reg[rcc_pkg::BIT_SLEEP];
   assign wrBufOffBit = wrData_reg[rcc_pkg::BIT_BUF_OFF];
   assign wrToRsvd = wrPulse_reg
      && ((wrAddr_reg >= rcc_pkg::ADDR_RSVD_A
      && wrAddr_reg <= rcc_pkg::ADDR_RSVD_D)
      || wrAddr_reg == rcc_pkg::ADDR_RSVD_E
      || wrAddr_reg == rcc_pkg::ADDR_RSVD_F);
   assign ptrOnRsvd = (ptr_reg >= rcc_pkg::ADDR_RSVD_A
      && ptr_reg <= rcc_pkg::ADDR_RSVD_D)
      || ptr_reg == rcc_pkg::ADDR_RSVD_E
      || ptr_reg == rcc_pkg::ADDR_RSVD_F;

   sequence s_ch2_write;
      wrPulse_reg && wrAddr_reg == rcc_pkg::ADDR_CH2_TH_GAIN
         && !broadcastWrite;
   endsequence
   sequence s_ch2_sleep_seen;
      ##2 channelSleep[1] == $past(wrSleepBit, 2);
   endsequence

   property p_sleep;
      @(posedge clk) disable iff (!rst_n)
      s_ch2_write |-> s_ch2_sleep_seen;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep output did not follow write");

   property p_buf_off;
      @(posedge clk) disable iff (!rst_n)
      wrPulse_reg && wrAddr_reg == rcc_pkg::ADDR_CH1_TH_GAIN
         |-> ##2 outputBufferOff[0] == $past(wrBufOffBit, 2);
   endproperty
   a_buf_off: assert property (p_buf_off)
      else $error("buffer off output did not follow write");

   property p_gain_undef;
      @(posedge clk) disable iff (!rst_n)
      thGain_reg[0][5:4] == rcc_pkg::GAIN_UNDEFINED
         |=> attenuationStep[0] == rcc_pkg::GAIN_DEFAULT;
   endproperty
   a_gain_undef: assert property (p_gain_undef)
      else $error("undefined gain code not held at default");

   property p_shift_neg;
      @(posedge clk) disable iff (!rst_n)
      thGain_reg[1][3] && thGain_reg[1][2:0] != 3'h0
         |=> decisionShift[1][3] && $signed(decisionShift[1])
         == -$signed({1'b0, $past(thGain_reg[1][2:0])});
   endproperty
   a_shift_neg: assert property (p_shift_neg)
      else $error("negative threshold shift wrong");

   property p_trim;
      @(posedge clk) disable iff (!rst_n)
      $changed(swing_reg) |=> bandwidthTrim
         == $past(swing_reg[rcc_pkg::TRIM_HI:rcc_pkg::TRIM_LO]);
   endproperty
   a_trim: assert property (p_trim)
      else $error("bandwidth trim did not follow register");

   property p_swing_upper;
      @(posedge clk) disable iff (!rst_n)
      swing_reg[rcc_pkg::SWING_HI] |=> outputSwingSteps
         == {1'b0, $past(swing_reg[rcc_pkg::SWING_MAG_HI:0])}
         + rcc_pkg::SWING_UPPER_BASE;
   endproperty
   a_swing_upper: assert property (p_swing_upper)
      else $error("upper swing codes below 250 mV");

   property p_map_swing;
      @(posedge clk) disable iff (!rst_n)
      wrPulse_reg && wrAddr_reg == rcc_pkg::ADDR_CH2_SWING_BW
         |=> swing_reg == $past(wrData_reg);
   endproperty
   a_map_swing: assert property (p_map_swing)
      else $error("swing register write lost");

   property p_reset_zero;
      @(posedge clk) disable iff (!rst_n)
      $past(!rst_n) |-> swing_reg == 8'h00 && thGain_reg[1] == 8'h00;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("channel 2 registers not zero after reset");

   property p_rsvd_write;
      @(posedge clk) disable iff (!rst_n)
      wrToRsvd |=> $stable(swing_reg) && $stable(thGain_reg);
   endproperty
   a_rsvd_write: assert property (p_rsvd_write)
      else $error("reserved write changed a register");

   property p_rsvd_read;
      @(posedge clk) disable iff (!rst_n)
      ptrOnRsvd |-> readByte == 8'h00;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved read not zero");

   property p_broadcast;
      @(posedge clk) disable iff (!rst_n)
      wrPulse_reg && broadcastWrite
         && wrAddr_reg == rcc_pkg::ADDR_CH1_TH_GAIN
         |=> thGain_reg[1] == $past(wrData_reg)
         && thGain_reg[0] == $past(wrData_reg);
   endproperty
   a_broadcast: assert property (p_broadcast)
      else $error("broadcast write not applied to all channels");
endmodule : rcc_ctrl_regs
`default_nettype wire

// file: verilog/rcc_ctrl_regs_dummy_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: dv/rcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_host_model (
   input wire logic clk,
   input wire logic sdaWire,
   output logic sclLine,
   output logic sdaPull
);
   // clocks spent on each half of the low phase; raise it for a slow host
   int lowHold = 4;

   initial begin
      sclLine = 1'b1;
      sdaPull = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // data only moves while the clock is low
   task automatic put_bit(input logic b, output logic seen);
      tick(1);
      sclLine <= 1'b0;
      tick(lowHold);
      sdaPull <= ~b;
      tick(lowHold);
      sclLine <= 1'b1;
      tick(4);
      seen = sdaWire;
      tick(2);
   endtask : put_bit

   // also serves as repeated start after an acknowledge
   task automatic start_cond();
      tick(1);
      sclLine <= 1'b0;
      tick(lowHold);
      sdaPull <= 1'b0;
      tick(lowHold);
      sclLine <= 1'b1;
      tick(4);
      sdaPull <= 1'b1;
      tick(4);
   endtask : start_cond

   task automatic stop_cond();
      tick(1);
      sclLine <= 1'b0;
      tick(lowHold);
      sdaPull <= 1'b1;
      tick(lowHold);
      sclLine <= 1'b1;
      tick(4);
      sdaPull <= 1'b0;
      tick(4);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) put_bit(d[i], s);
      put_bit(1'b1, s);
      ack = ~s;
   endtask : send_byte

   // last byte is answered with a not-acknowledge
   task automatic recv_byte(input logic last, output logic [7:0] d);
      logic s;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         put_bit(1'b1, s);
         d = {d[6:0], s};
      end
      put_bit(last, s);
   endtask : recv_byte

   task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                            input logic [7:0] data, output logic [2:0] acks);
      acks = 3'h0;
      start_cond();
      send_byte({dev, 1'b0}, acks[2]);
      if (acks[2]) begin
         send_byte(addr, acks[1]);
         send_byte(data, acks[0]);
      end
      stop_cond();
   endtask : write_reg

   task automatic read_reg(input logic [6:0] dev, input logic [7:0] addr,
                           output logic [7:0] data, output logic ok);
      logic a0, a1, a2;
      start_cond();
      send_byte({dev, 1'b0}, a0);
      send_byte(addr, a1);
      start_cond();
      send_byte({dev, 1'b1}, a2);
      recv_byte(1'b1, data);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask : read_reg
endmodule : rcc_host_model
`default_nettype wire

// file: dv/rcc_ctrl_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rcc_ctrl_regs_tb_top;
   localparam logic [6:0] DEV = rcc_pkg::DEV_ADDR_DEFAULT;
   logic clk, rst_n, broadcastWrite, sclLine, sdaPull, sdaIn, sdaOut, sdaOe;
   logic [rcc_pkg::NUM_CH-1:0] channelSleep, outputBufferOff;
   logic [rcc_pkg::NUM_CH-1:0][1:0] attenuationStep;
   logic [rcc_pkg::NUM_CH-1:0][3:0] decisionShift;
   logic [3:0] bandwidthTrim, outputSwingSteps;
   logic [7:0] expCtrl [2];
   logic [7:0] expSwing;
   int error_cnt = 0;
   int compares = 0;

   // open-drain data line with pull-up
   assign sdaIn = ~(sdaPull | sdaOe);
   always #12.5 clk = ~clk;

   rcc_ctrl_regs #(.DEV_ADDR(DEV)) dut_u (.clk(clk), .rst_n(rst_n),
      .sclIn(sclLine), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .broadcastWrite(broadcastWrite), .channelSleep(channelSleep),
      .outputBufferOff(outputBufferOff), .attenuationStep(attenuationStep),
      .decisionShift(decisionShift), .bandwidthTrim(bandwidthTrim),
      .outputSwingSteps(outputSwingSteps));
   rcc_host_model host_u (.clk(clk), .sdaWire(sdaIn), .sclLine(sclLine),
      .sdaPull(sdaPull));

   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [7:0] ctrl_exp(input logic [7:0] b);
      return {b[7:6], (b[5:4] == 2'h1) ? 2'h0 : b[5:4],
              b[3] ? 4'h0 - {1'b0, b[2:0]} : {1'b0, b[2:0]}};
   endfunction : ctrl_exp

   function automatic logic [7:0] ctrl_now(input int c);
      return {channelSleep[c], outputBufferOff[c], attenuationStep[c],
              decisionShift[c]};
   endfunction : ctrl_now

   function automatic logic [7:0] swing_exp(input logic [7:0] b);
      return {b[7:4], b[3] ? b[3:0] - 4'h3 : b[3:0]};
   endfunction : swing_exp

   task automatic chk_all();
      chk("ch1 controls", ctrl_exp(expCtrl[0]), ctrl_now(0));
      chk("ch2 controls", ctrl_exp(expCtrl[1]), ctrl_now(1));
      chk("ch2 trim swing", swing_exp(expSwing),
          {bandwidthTrim, outputSwingSteps});
   endtask : chk_all

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic [2:0] a;
      host_u.write_reg(DEV, addr, data, a);
      chk("write acks", 8'h07, {5'h00, a});
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] addr,
                         input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host_u.read_reg(DEV, addr, d, ok);
      chk("read acks", 8'h01, {7'h00, ok});
      chk(what, exp, d);
   endtask : rd_chk

   task automatic t_reset();
      expCtrl = '{8'h00, 8'h00};
      expSwing = 8'h00;
      chk_all();
      chk("data enable", 8'h00, {7'h00, sdaOe});
      chk("data out", 8'h00, {7'h00, sdaOut});
      rd_chk("ch2 swing reset", rcc_pkg::ADDR_CH2_SWING_BW, 8'h00);
      rd_chk("ch2 ctrl reset", rcc_pkg::ADDR_CH2_TH_GAIN, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ctrl();
      logic [7:0] pat [9];
      pat = '{8'h81, 8'h40, 8'h20, 8'h30, 8'h10, 8'h07, 8'h08, 8'h0F, 8'h09};
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 9; i++) begin
            wr(rcc_pkg::ADDR_TH_GAIN[c], pat[i]);
            expCtrl[c] = pat[i];
            chk_all();
            rd_chk("ctrl readback", rcc_pkg::ADDR_TH_GAIN[c], pat[i]);
         end
      end
      $display("test channel controls done");
   endtask : t_ctrl

   task automatic t_swing();
      logic [7:0] pat [5];
      pat = '{8'h70, 8'hF7, 8'h08, 8'h1F, 8'h00};
      for (int i = 0; i < 5; i++) begin
         wr(rcc_pkg::ADDR_CH2_SWING_BW, pat[i]);
         expSwing = pat[i];
         chk_all();
         rd_chk("swing readback", rcc_pkg::ADDR_CH2_SWING_BW, pat[i]);
      end
      $display("test trim and swing done");
   endtask : t_swing

   task automatic t_reserved();
      logic [7:0] adr [7];
      adr = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B};
      for (int i = 0; i < 7; i++) begin
         wr(adr[i], 8'hFF);
         chk_all();
         rd_chk("reserved read", adr[i], 8'h00);
      end
      $display("test reserved done");
   endtask : t_reserved

   task automatic t_bcast();
      @(posedge clk) broadcastWrite <= 1'b1;
      wr(rcc_pkg::ADDR_CH1_TH_GAIN, 8'hA5);
      expCtrl = '{8'hA5, 8'hA5};
      chk_all();
      wr(rcc_pkg::ADDR_CH2_TH_GAIN, 8'h3A);
      expCtrl = '{8'h3A, 8'h3A};
      chk_all();
      wr(rcc_pkg::ADDR_CH1_SWING_BW, 8'h9C);
      expSwing = 8'h9C;
      chk_all();
      @(posedge clk) broadcastWrite <= 1'b0;
      wr(rcc_pkg::ADDR_CH1_SWING_BW, 8'h11);
      wr(rcc_pkg::ADDR_CH1_TH_GAIN, 8'h00);
      expCtrl[0] = 8'h00;
      chk_all();
      $display("test broadcast done");
   endtask : t_bcast

   task automatic t_wrong_dev();
      logic [2:0] a;
      host_u.lowHold = 12;
      host_u.write_reg(DEV ^ 7'h01, rcc_pkg::ADDR_CH2_TH_GAIN, 8'hFF, a);
      chk("foreign acks", 8'h00, {5'h00, a});
      chk_all();
      wr(rcc_pkg::ADDR_CH2_TH_GAIN, 8'hD9);
      expCtrl[1] = 8'hD9;
      chk_all();
      host_u.lowHold = 4;
      $display("test foreign device and slow host done");
   endtask : t_wrong_dev

   task automatic t_rst_again();
      @(posedge clk) rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      expCtrl = '{8'h00, 8'h00};
      expSwing = 8'h00;
      chk_all();
      $display("test second reset done");
   endtask : t_rst_again

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      broadcastWrite = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_ctrl();
      t_swing();
      t_reserved();
      t_bcast();
      t_wrong_dev();
      t_rst_again();
      finish_test();
   end

   initial begin
      repeat (100000) @(posedge clk);
      error_cnt++;
      $display("BAD run length expected done seen hang");
      finish_test();
   end
endmodule : rcc_ctrl_regs_tb_top
`default_nettype wire
